// File: hdl/sltc_dec8b10b.v
/*
  8B/10B code group checker for one byte lane: flags invalid code groups,
  running disparity faults and commas, and gives the next disparity.
  Assumes i_sym bit 0 is the first bit received (a).
*/
`timescale 1ns/100ps
`default_nettype none
`include "sltc_lane_map.vh"

module sltc_dec8b10b (
  input wire [9:0] i_sym,
  input wire i_rd,
  output reg o_rd,
  output reg o_invalid,
  output reg o_disp_err,
  output reg o_comma
);

  reg [3:0] ones6;
  reg [2:0] ones4;
  reg [5:0] b6;
  reg [3:0] b4;
  reg rd_mid;

  // ----------------------------------------
  // Sub-block disparity and validity checks
  // ----------------------------------------
  always @*
  begin
    b6 = i_sym[5:0];
    b4 = i_sym[9:6];
    ones6 = {3'h0, b6[0]} + {3'h0, b6[1]} + {3'h0, b6[2]} + {3'h0, b6[3]} + {3'h0, b6[4]} + {3'h0, b6[5]};
    ones4 = {2'h0, b4[0]} + {2'h0, b4[1]} + {2'h0, b4[2]} + {2'h0, b4[3]};
    o_invalid = 1'b0;
    o_disp_err = 1'b0;
    // Unbalanced blocks must be +/-2 and flip disparity
    if (ones6 != 4'h3 && ones6 != 4'h2 && ones6 != 4'h4)
      o_invalid = 1'b1;
    if (b6 == 6'h00 || b6 == 6'h3f || b6 == 6'h0f || b6 == 6'h30)
      o_invalid = 1'b1;
    if (ones4 == 3'h0 || ones4 == 3'h4)
      o_invalid = 1'b1;
    rd_mid = i_rd;
    if (ones6 == 4'h4)
    begin
      o_disp_err = o_disp_err | i_rd;
      rd_mid = 1'b1;
    end
    else if (ones6 == 4'h2)
    begin
      o_disp_err = o_disp_err | ~i_rd;
      rd_mid = 1'b0;
    end
    o_rd = rd_mid;
    if (ones4 == 3'h3)
    begin
      o_disp_err = o_disp_err | rd_mid;
      o_rd = 1'b1;
    end
    else if (ones4 == 3'h1)
    begin
      o_disp_err = o_disp_err | ~rd_mid;
      o_rd = 1'b0;
    end
    o_comma = (i_sym[6:0] == `SLTC_COMMA_P) || (i_sym[6:0] == `SLTC_COMMA_N);
  end

endmodule

`default_nettype wire

// File: hdl/sltc_lane.v
/*
  Test and status logic of one serial lane: line polarity, transmit block,
  pattern generation and checking with error injection, equalizer path and
  boost control, clock recovery hold, and per-byte 8B/10B status.
  Assumes i_clk is the 156 MHz-class core clock of the lane; the parallel
  serial-side words arrive and leave on i_clk. Inputs marked asynchronous
  pass two flip-flops here.

// What this block does
// - Invert transmitted data when tx invert set
// - Invert received data before decoding when set
// - Low picks feedback path, high linear path
// - Datapath reset clears both equalizer paths
// - High boost freezes or keeps adapting
// - High boost from attribute or hold signal
// - Low boost freezes or keeps adapting
// - Low boost from attribute or hold signal
// - Transmit block suppresses serial output data
// - Count clear zeroes pattern error counter
// - Pattern error flag non-sticky, live only
// - Three-bit checker select, including off
// - Three-bit generator select, including normal traffic
// - Error inject corrupts generator while high
// - Clock recovery freeze holds loop state
// - Per-byte disparity fault vector, active high
// - Per-byte invalid code vector, active high
// - Alignment flag whenever comma is detected
*/
`timescale 1ns/100ps
`default_nettype none
`include "sltc_lane_map.vh"

module sltc_lane #(
  parameter BYTES = 4,
  parameter CNT_W = 16,
  parameter [`SLTC_BOOST_W-1:0] HF_ATTR = `SLTC_BOOST_RST,
  parameter [`SLTC_BOOST_W-1:0] LF_ATTR = `SLTC_BOOST_RST
) (
  input wire i_clk,
  input wire i_sys_rst,
  input wire i_ce,
  input wire [BYTES*10-1:0] i_tx_word,
  input wire [BYTES*10-1:0] i_rx_word,
  input wire i_tx_line_invert,
  input wire i_rx_line_invert,
  input wire i_rx_equalizer_path_select,
  input wire i_equalizer_datapath_reset,
  input wire i_linear_eq_reset_pulse,
  input wire i_high_boost_freeze,
  input wire i_high_boost_override,
  input wire i_low_boost_freeze,
  input wire i_low_boost_override,
  input wire i_tx_output_block,
  input wire i_pattern_error_count_clear,
  input wire [2:0] i_rx_pattern_check_select,
  input wire [2:0] i_tx_pattern_gen_select,
  input wire i_tx_pattern_error_inject,
  input wire i_clock_recovery_freeze,
  output reg [BYTES*10-1:0] o_tx_word,
  output reg o_pattern_error_flag,
  output reg [CNT_W-1:0] o_pattern_error_count,
  output reg [BYTES-1:0] o_rx_disparity_fault,
  output reg [BYTES-1:0] o_rx_invalid_code_flag,
  output reg o_rx_align_char_seen,
  output reg [BYTES*8-1:0] o_rx_raw_byte,
  output reg o_eq_path_linear,
  output reg o_eq_in_reset,
  output reg [`SLTC_BOOST_W-1:0] o_high_boost,
  output reg [`SLTC_BOOST_W-1:0] o_low_boost,
  output reg [5:0] o_cdr_phase
);

  localparam W = BYTES * 10;
  localparam [CNT_W-1:0] CNT_MAX = {CNT_W{1'b1}};

  // ----------------------------------------
  // Synchronisers for asynchronous control inputs
  // ----------------------------------------
  reg [6:0] async_s1_r;
  reg [6:0] async_s2_r;
  wire eq_path_s = async_s2_r[0];
  wire eq_rst_s = async_s2_r[1];
  wire hf_hold_s = async_s2_r[2];
  wire hf_ovr_s = async_s2_r[3];
  wire lf_hold_s = async_s2_r[4];
  wire lf_ovr_s = async_s2_r[5];
  wire cdr_hold_s = async_s2_r[6];

  // Two-stage capture; first stage feeds only the second
  always @(posedge i_clk)
  begin
    if (i_sys_rst)
    begin
      async_s1_r <= 7'h00;
      async_s2_r <= 7'h00;
    end
    else if (i_ce)
    begin
      async_s1_r <= {i_clock_recovery_freeze, i_low_boost_override, i_low_boost_freeze,
        i_high_boost_override, i_high_boost_freeze, i_equalizer_datapath_reset,
        i_rx_equalizer_path_select};
      async_s2_r <= async_s1_r;
    end
  end

  // ----------------------------------------
  // Transmit pattern generator
  // ----------------------------------------
  reg [30:0] tx_lfsr_r;
  wire [30:0] tx_lfsr_nxt;
  wire [W-1:0] tx_bits;
  reg [W-1:0] tx_data;

  sltc_prbs #(.W(W)) u_tx_prbs (
    .i_sel(i_tx_pattern_gen_select),
    .i_state(tx_lfsr_r),
    .o_state(tx_lfsr_nxt),
    .o_bits(tx_bits)
  );

  // Select traffic or pattern, inject errors, invert, block
  always @*
  begin
    if (i_tx_pattern_gen_select == `SLTC_PAT_OFF)
      tx_data = i_tx_word;
    else
      tx_data = tx_bits ^ {{(W-1){1'b0}}, i_tx_pattern_error_inject};
    if (i_tx_line_invert)
      tx_data = ~tx_data;
    if (i_tx_output_block)
      tx_data = {W{1'b0}};
  end

  // Generator state and registered serial word
  always @(posedge i_clk)
  begin
    if (i_sys_rst)
    begin
      tx_lfsr_r <= `SLTC_LFSR_SEED;
      o_tx_word <= {W{1'b0}};
    end
    else if (i_ce)
    begin
      tx_lfsr_r <= (i_tx_pattern_gen_select == `SLTC_PAT_OFF) ? `SLTC_LFSR_SEED : tx_lfsr_nxt;
      o_tx_word <= tx_data;
    end
  end

  // ----------------------------------------
  // Receive polarity and pattern checker
  // ----------------------------------------
  wire [W-1:0] rx_data = i_rx_line_invert ? ~i_rx_word : i_rx_word;
  reg [30:0] rx_lfsr_r;
  wire [30:0] rx_lfsr_nxt;
  wire [W-1:0] rx_expect;
  wire [30:0] rx_seed;
  genvar gs;

  // Reseed from the newest 31 bits; the step leaves its last bit in state bit 0
  generate
    for (gs = 0; gs < 31; gs = gs + 1)
    begin : g_seed
      assign rx_seed[gs] = rx_data[W-1-gs];
    end
  endgenerate
  wire rx_mismatch = (i_rx_pattern_check_select != `SLTC_PAT_OFF) && (rx_expect != rx_data);

  // Self-synchronising check: expected word derived from the previous received bits
  sltc_prbs #(.W(W)) u_rx_prbs (
    .i_sel(i_rx_pattern_check_select),
    .i_state(rx_lfsr_r),
    .o_state(rx_lfsr_nxt),
    .o_bits(rx_expect)
  );

  // Checker state, live error flag and saturating counter
  always @(posedge i_clk)
  begin
    if (i_sys_rst)
    begin
      rx_lfsr_r <= `SLTC_LFSR_SEED;
      o_pattern_error_flag <= 1'b0;
      o_pattern_error_count <= {CNT_W{1'b0}};
    end
    else if (i_ce)
    begin
      rx_lfsr_r <= rx_mismatch ? rx_seed : rx_lfsr_nxt;
      o_pattern_error_flag <= rx_mismatch;
      if (i_pattern_error_count_clear)
        o_pattern_error_count <= {CNT_W{1'b0}};
      else if (rx_mismatch && o_pattern_error_count != CNT_MAX)
        o_pattern_error_count <= o_pattern_error_count + {{(CNT_W-1){1'b0}}, 1'b1};
    end
  end

  // ----------------------------------------
  // Per-byte 8B/10B status
  // ----------------------------------------
  wire [BYTES:0] rd_chain;
  wire [BYTES-1:0] inv_v;
  wire [BYTES-1:0] derr_v;
  wire [BYTES-1:0] comma_v;
  reg rd_r;
  assign rd_chain[0] = rd_r;

  genvar g;
  generate
    for (g = 0; g < BYTES; g = g + 1)
    begin : g_byte
      sltc_dec8b10b u_dec (
        .i_sym(rx_data[g*10 +: 10]),
        .i_rd(rd_chain[g]),
        .o_rd(rd_chain[g+1]),
        .o_invalid(inv_v[g]),
        .o_disp_err(derr_v[g]),
        .o_comma(comma_v[g])
      );
    end
  endgenerate

  // Registered status vectors and running disparity
  always @(posedge i_clk)
  begin
    if (i_sys_rst)
    begin
      rd_r <= 1'b0;
      o_rx_disparity_fault <= {BYTES{1'b0}};
      o_rx_invalid_code_flag <= {BYTES{1'b0}};
      o_rx_align_char_seen <= 1'b0;
      o_rx_raw_byte <= {BYTES*8{1'b0}};
    end
    else if (i_ce)
    begin
      rd_r <= rd_chain[BYTES];
      o_rx_disparity_fault <= derr_v;
      o_rx_invalid_code_flag <= inv_v;
      o_rx_align_char_seen <= |comma_v;
      o_rx_raw_byte <= {BYTES*8{1'b0}};
    end
  end

  // ----------------------------------------
  // Equalizer path, resets and boost adaptation
  // ----------------------------------------
  reg lpm_rst_d_r;
  reg lpm_rst_go_r;
  wire boost_up = rx_mismatch;

  // Linear reset starts on release of the pulse input
  always @(posedge i_clk)
  begin
    if (i_sys_rst)
    begin
      lpm_rst_d_r <= 1'b0;
      lpm_rst_go_r <= 1'b0;
    end
    else if (i_ce)
    begin
      lpm_rst_d_r <= i_linear_eq_reset_pulse;
      lpm_rst_go_r <= lpm_rst_d_r & ~i_linear_eq_reset_pulse;
    end
  end

  // Boost values: reset, attribute override, hold, or adapt
  always @(posedge i_clk)
  begin
    if (i_sys_rst)
    begin
      o_eq_path_linear <= 1'b0;
      o_eq_in_reset <= 1'b0;
      o_high_boost <= `SLTC_BOOST_RST;
      o_low_boost <= `SLTC_BOOST_RST;
    end
    else if (i_ce)
    begin
      o_eq_path_linear <= eq_path_s;
      o_eq_in_reset <= eq_rst_s | lpm_rst_go_r;
      if (eq_rst_s)
      begin
        o_high_boost <= `SLTC_BOOST_RST;
        o_low_boost <= `SLTC_BOOST_RST;
      end
      else
      begin
        if (lpm_rst_go_r && eq_path_s)
          o_high_boost <= `SLTC_BOOST_RST;
        else if (hf_ovr_s)
          o_high_boost <= HF_ATTR;
        else if (!hf_hold_s && eq_path_s && boost_up && o_high_boost != `SLTC_BOOST_MAX)
          o_high_boost <= o_high_boost + 5'h01;
        if (lpm_rst_go_r && eq_path_s)
          o_low_boost <= `SLTC_BOOST_RST;
        else if (lf_ovr_s)
          o_low_boost <= LF_ATTR;
        else if (!lf_hold_s && eq_path_s && boost_up && o_low_boost != `SLTC_BOOST_MIN)
          o_low_boost <= o_low_boost - 5'h01;
      end
    end
  end

  // ----------------------------------------
  // Clock recovery phase tracking
  // ----------------------------------------
  wire rx_edge_early = rx_data[0] ^ rx_data[1];

  // Phase accumulator steps when rx_data bits 0 and 1 differ, unless frozen
  always @(posedge i_clk)
  begin
    if (i_sys_rst)
      o_cdr_phase <= `SLTC_CDR_PHASE_RST;
    else if (i_ce && !cdr_hold_s && rx_edge_early)
      o_cdr_phase <= o_cdr_phase + 6'h01;
  end

endmodule

`default_nettype wire

// File: hdl/sltc_lane_map.vh
/*
  Constants for the lane test and status block: pattern select codes,
  8B/10B comma patterns of both disparities, equalizer boost defaults.
  Assumes inclusion by bare name from files of this block.
*/
`ifndef SLTC_LANE_MAP_VH
`define SLTC_LANE_MAP_VH

// ----------------------------------------
// Pattern select codes
// ----------------------------------------
`define SLTC_PAT_OFF    3'h0
`define SLTC_PAT_PRBS7  3'h1
`define SLTC_PAT_PRBS15 3'h2
`define SLTC_PAT_PRBS23 3'h3
`define SLTC_PAT_PRBS31 3'h4
`define SLTC_LFSR_SEED  31'h7fffffff

// ----------------------------------------
// 8B/10B comma patterns (positive and negative)
// ----------------------------------------
`define SLTC_COMMA_P 7'h7c
`define SLTC_COMMA_N 7'h03

// ----------------------------------------
// Equalizer boost and recovery phase values
// ----------------------------------------
`define SLTC_BOOST_W     5
`define SLTC_BOOST_RST   5'h10
`define SLTC_BOOST_MAX   5'h1f
`define SLTC_BOOST_MIN   5'h00
`define SLTC_CDR_PHASE_RST 6'h00

`endif

// File: hdl/sltc_prbs.v
/*
  Parallel PRBS step: advances a 31-bit scrambler state by W bits for the
  selected polynomial and gives the W bits produced.
  Assumes the caller holds the state register.
*/
`timescale 1ns/100ps
`default_nettype none
`include "sltc_lane_map.vh"

module sltc_prbs #(
  parameter W = 40
) (
  input wire [2:0] i_sel,
  input wire [30:0] i_state,
  output reg [30:0] o_state,
  output reg [W-1:0] o_bits
);

  integer k;
  reg fb;

  // ----------------------------------------
  // Bit-serial unroll of the selected polynomial
  // ----------------------------------------
  always @*
  begin
    o_state = i_state;
    o_bits = {W{1'b0}};
    fb = 1'b0;
    for (k = 0; k < W; k = k + 1)
    begin
      case (i_sel)
        `SLTC_PAT_PRBS7: fb = o_state[6] ^ o_state[5];
        `SLTC_PAT_PRBS15: fb = o_state[14] ^ o_state[13];
        `SLTC_PAT_PRBS23: fb = o_state[22] ^ o_state[17];
        default: fb = o_state[30] ^ o_state[27];
      endcase
      o_bits[k] = fb;
      o_state = {o_state[29:0], fb};
    end
  end

endmodule

`default_nettype wire

// File: tb/sltc_chk.sv
/*
  Port checker of the lane test and status block.
  Assumes a bind onto sltc_lane, one clock, synchronous reset.
*/
`timescale 1ns/100ps
`default_nettype none
module sltc_chk #(
  parameter BYTES = 4,
  parameter CNT_W = 16
) (
  input wire logic i_clk,
  input wire logic i_sys_rst,
  input wire logic i_ce,
  input wire logic [BYTES*10-1:0] i_tx_word,
  input wire logic i_tx_line_invert,
  input wire logic i_tx_output_block,
  input wire logic [2:0] i_tx_pattern_gen_select,
  input wire logic [2:0] i_rx_pattern_check_select,
  input wire logic i_pattern_error_count_clear,
  input wire logic i_rx_equalizer_path_select,
  input wire logic i_equalizer_datapath_reset,
  input wire logic i_linear_eq_reset_pulse,
  input wire logic i_high_boost_freeze,
  input wire logic i_high_boost_override,
  input wire logic i_low_boost_freeze,
  input wire logic i_low_boost_override,
  input wire logic i_clock_recovery_freeze,
  input wire logic [BYTES*10-1:0] o_tx_word,
  input wire logic o_pattern_error_flag,
  input wire logic [CNT_W-1:0] o_pattern_error_count,
  input wire logic o_eq_path_linear,
  input wire logic o_eq_in_reset,
  input wire logic [4:0] o_high_boost,
  input wire logic [4:0] o_low_boost,
  input wire logic [5:0] o_cdr_phase
);
  // ----------------------------------------
  // Clocking and shared terms
  // ----------------------------------------
  default clocking cb @(posedge i_clk);
  endclocking
  default disable iff (i_sys_rst);
  wire tx_plain = i_ce && i_tx_pattern_gen_select == 3'h0 && !i_tx_output_block;
  wire quiet = !i_equalizer_datapath_reset && !i_linear_eq_reset_pulse;
  // Level held long enough to pass the sync flops and the output register
  sequence s_held(logic s);
    (i_ce && s)[*5];
  endsequence
  // ----------------------------------------
  // Assertions
  // ----------------------------------------
  AST_TX_PASS: assert property (tx_plain && !i_tx_line_invert |=> o_tx_word == $past(i_tx_word))
    else $error("tx word not passed through");
  AST_TX_INV: assert property (tx_plain && i_tx_line_invert |=> o_tx_word == ~$past(i_tx_word))
    else $error("tx word not inverted");
  AST_TX_BLOCK: assert property (i_ce && i_tx_output_block |=> o_tx_word == '0)
    else $error("tx word not blocked");
  AST_CNT_CLR: assert property (i_ce && i_pattern_error_count_clear |=> o_pattern_error_count == '0)
    else $error("error count not cleared");
  AST_CHK_OFF: assert property (i_ce && i_rx_pattern_check_select == 3'h0 |=> !o_pattern_error_flag)
    else $error("error flag while checker off");
  AST_PATH_LIN: assert property (s_held(i_rx_equalizer_path_select) |-> o_eq_path_linear)
    else $error("linear path not chosen");
  AST_PATH_DFE: assert property (s_held(!i_rx_equalizer_path_select) |-> !o_eq_path_linear)
    else $error("feedback path not chosen");
  AST_DP_RST: assert property (s_held(i_equalizer_datapath_reset) |-> o_eq_in_reset)
    else $error("datapath reset not applied");
  AST_HF_HOLD: assert property (s_held(i_high_boost_freeze && !i_high_boost_override && quiet) |=> $stable(o_high_boost))
    else $error("high boost moved while frozen");
  AST_LF_HOLD: assert property (s_held(i_low_boost_freeze && !i_low_boost_override && quiet) |=> $stable(o_low_boost))
    else $error("low boost moved while frozen");
  AST_CDR_HOLD: assert property (s_held(i_clock_recovery_freeze) |=> $stable(o_cdr_phase))
    else $error("recovery phase moved while frozen");
endmodule
bind sltc_lane sltc_chk #(.BYTES(BYTES), .CNT_W(CNT_W)) sltc_chk_inst (.*);
`default_nettype wire

// File: tb/sltc_rx_model.sv
/*
  Far side of the lane: line loopback or fixed receive word, and the
  controller's linear equalizer reset pulse.
  Assumes everything runs on the core clock.
*/
`timescale 1ns/100ps
`default_nettype none
module sltc_rx_model (
  input wire logic i_clk,
  input wire logic i_loop,
  input wire logic i_lin_req,
  input wire logic [39:0] i_tx_word,
  input wire logic [39:0] i_word,
  output logic [39:0] o_rx_word,
  output logic o_lin_pulse
);
  logic [39:0] line_r = 40'h0;
  logic [1:0] pulse_r = 2'h0;
  // One cycle of line delay, kept in the core domain
  always @(posedge i_clk)
  begin
    line_r <= i_tx_word;
    pulse_r <= i_lin_req ? 2'h3 : {pulse_r[0], 1'b0};
  end
  assign o_rx_word = i_loop ? line_r : i_word;
  // Drive high for two cycles, then release to start the reset
  assign o_lin_pulse = pulse_r[1];
endmodule
`default_nettype wire

// File: tb/tb.sv
/*
  Self-checking bench of the lane test and status block.
  Assumes the checker and the far side model are compiled first.
*/
`timescale 1ns/100ps
`default_nettype none
module tb;
  logic i_clk, i_sys_rst, i_ce, i_tx_line_invert, i_rx_line_invert, i_rx_equalizer_path_select;
  logic i_equalizer_datapath_reset, i_high_boost_freeze, i_high_boost_override, i_low_boost_freeze;
  logic i_low_boost_override, i_tx_output_block, i_pattern_error_count_clear, i_tx_pattern_error_inject;
  logic i_clock_recovery_freeze, loop, lreq, o_pattern_error_flag, o_rx_align_char_seen;
  logic o_eq_path_linear, o_eq_in_reset, i_linear_eq_reset_pulse;
  logic [2:0] i_rx_pattern_check_select, i_tx_pattern_gen_select;
  logic [39:0] i_tx_word, i_rx_word, o_tx_word, rword;
  logic [15:0] o_pattern_error_count;
  logic [3:0] o_rx_disparity_fault, o_rx_invalid_code_flag;
  logic [31:0] o_rx_raw_byte;
  logic [4:0] o_high_boost, o_low_boost;
  logic [5:0] o_cdr_phase, ph;
  int n_fail = 0;
  int n_compared = 0;
  localparam logic [39:0] GOOD = {10'h283, 10'h17c, 10'h283, 10'h17c};
  sltc_lane #(.HF_ATTR(5'h0a), .LF_ATTR(5'h05)) sltc_lane_inst (.*);
  sltc_rx_model sltc_rx_model_inst (.i_clk(i_clk), .i_loop(loop), .i_lin_req(lreq), .i_tx_word(o_tx_word),
    .i_word(rword), .o_rx_word(i_rx_word), .o_lin_pulse(i_linear_eq_reset_pulse));
  // ----------------------------------------
  // Shared tasks
  // ----------------------------------------
  task tick(input int n);
    repeat (n) @(posedge i_clk);
  endtask
  task chk(input bit ok, input string m);
    n_compared++;
    if (!ok)
    begin
      n_fail++;
      $display("[FAIL] %0t %s", $time, m);
    end
  endtask
  task report_and_stop;
    if (n_fail == 0 && n_compared > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask
  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  // Pass-through, inversion, blocking and clock enable on the tx word
  task t_tx;
    @(posedge i_clk);
    i_tx_word <= 40'h12_3456_789a;
    tick(2);
    #1 chk(o_tx_word === 40'h12_3456_789a, "tx pass");
    i_tx_line_invert <= 1'b1;
    tick(2);
    #1 chk(o_tx_word === ~40'h12_3456_789a, "tx invert");
    i_tx_output_block <= 1'b1;
    tick(2);
    #1 chk(o_tx_word === 40'h0, "tx block");
    i_ce <= 1'b0;
    i_tx_output_block <= 1'b0;
    tick(2);
    #1 chk(o_tx_word === 40'h0, "ce hold");
    i_ce <= 1'b1;
    i_tx_line_invert <= 1'b0;
  endtask
  // Every pattern looped back: lock, inject, relock, clear
  task t_prbs;
    loop <= 1'b1;
    for (int c = 1; c < 5; c++)
    begin
      @(posedge i_clk);
      i_tx_pattern_gen_select <= c[2:0];
      i_rx_pattern_check_select <= c[2:0];
      tick(30);
      #1 chk(o_pattern_error_flag === 1'b0, "no lock");
      i_tx_pattern_error_inject <= 1'b1;
      tick(4);
      #1 chk(o_pattern_error_flag === 1'b1, "inject unseen");
      i_tx_pattern_error_inject <= 1'b0;
      tick(30);
      #1 chk(o_pattern_error_flag === 1'b0 && o_pattern_error_count !== 16'h0, "flag sticky");
      i_pattern_error_count_clear <= 1'b1;
      tick(2);
      #1 chk(o_pattern_error_count === 16'h0, "count kept");
      i_pattern_error_count_clear <= 1'b0;
    end
    i_rx_pattern_check_select <= 3'h0;
    i_tx_pattern_error_inject <= 1'b1;
    tick(6);
    #1 chk(o_pattern_error_flag === 1'b0, "checker not off");
    i_tx_pattern_error_inject <= 1'b0;
    i_tx_pattern_gen_select <= 3'h0;
  endtask
  // Comma words, inverted line, disparity and code faults
  task t_stat;
    loop <= 1'b0;
    rword <= GOOD;
    tick(4);
    #1 chk(o_rx_align_char_seen === 1'b1 && o_rx_disparity_fault === 4'h0, "comma word");
    rword <= ~GOOD;
    i_rx_line_invert <= 1'b1;
    tick(3);
    #1 chk(o_rx_align_char_seen === 1'b1 && o_rx_disparity_fault === 4'h0, "rx invert");
    rword <= {4{10'h17c}};
    i_rx_line_invert <= 1'b0;
    tick(1);
    #1 chk(o_rx_disparity_fault[1:0] === 2'h2, "disparity");
    rword <= 40'h0;
    tick(2);
    #1 chk(o_rx_invalid_code_flag === 4'hf && o_rx_align_char_seen === 1'b0, "invalid");
    chk(o_rx_raw_byte === 32'h0, "spare byte output not zero");
  endtask
  // Equalizer path, boosts, resets and recovery hold
  task t_eq;
    i_rx_equalizer_path_select <= 1'b1;
    i_high_boost_override <= 1'b1;
    i_low_boost_override <= 1'b1;
    tick(5);
    #1 chk(o_eq_path_linear === 1'b1, "path");
    chk(o_high_boost === 5'h0a && o_low_boost === 5'h05, "override");
    i_high_boost_override <= 1'b0;
    i_low_boost_override <= 1'b0;
    i_high_boost_freeze <= 1'b1;
    i_low_boost_freeze <= 1'b1;
    loop <= 1'b1;
    i_tx_pattern_gen_select <= 3'h1;
    i_rx_pattern_check_select <= 3'h1;
    i_tx_pattern_error_inject <= 1'b1;
    tick(10);
    #1 chk(o_high_boost === 5'h0a && o_low_boost === 5'h05, "not held");
    i_high_boost_freeze <= 1'b0;
    i_low_boost_freeze <= 1'b0;
    tick(10);
    #1 chk(o_high_boost !== 5'h0a && o_low_boost !== 5'h05, "not adapting");
    i_tx_pattern_error_inject <= 1'b0;
    i_rx_pattern_check_select <= 3'h0;
    lreq <= 1'b1;
    tick(1);
    lreq <= 1'b0;
    tick(8);
    #1 chk(o_high_boost === 5'h10 && o_low_boost === 5'h10, "linear reset");
    i_equalizer_datapath_reset <= 1'b1;
    tick(5);
    #1 chk(o_eq_in_reset === 1'b1, "dp reset");
    i_equalizer_datapath_reset <= 1'b0;
    loop <= 1'b0;
    rword <= 40'h1;
    i_clock_recovery_freeze <= 1'b1;
    tick(5);
    #1 ph = o_cdr_phase;
    tick(5);
    #1 chk(o_cdr_phase === ph, "cdr moved");
    i_clock_recovery_freeze <= 1'b0;
    i_rx_equalizer_path_select <= 1'b0;
    tick(5);
    #1 chk(o_cdr_phase !== ph && o_eq_path_linear === 1'b0, "cdr stuck");
  endtask
  // ----------------------------------------
  // Clock, watchdog and main sequence
  // ----------------------------------------
  initial
  begin
    i_clk = 1'b0;
    forever #2.5 i_clk = ~i_clk;
  end
  initial
  begin
    #50000;
    n_fail++;
    report_and_stop();
  end
  initial
  begin
    {i_ce, i_tx_line_invert, i_rx_line_invert, i_rx_equalizer_path_select, i_equalizer_datapath_reset} = 5'h10;
    {i_high_boost_freeze, i_high_boost_override, i_low_boost_freeze, i_low_boost_override} = 4'h0;
    {i_tx_output_block, i_pattern_error_count_clear, i_tx_pattern_error_inject} = 3'h0;
    {i_clock_recovery_freeze, loop, lreq, i_rx_pattern_check_select, i_tx_pattern_gen_select} = 9'h0;
    i_tx_word = 40'h0;
    rword = 40'h0;
    i_sys_rst = 1'b1;
    tick(10);
    i_sys_rst <= 1'b0;
    t_tx();
    t_prbs();
    t_stat();
    t_eq();
    report_and_stop();
  end
endmodule
`default_nettype wire
